// >>> alb_cfg.svh
// constants of the arithmetic, logic and control-transfer execution unit
`ifndef ALB_CFG_SVH
`define ALB_CFG_SVH

// ----------------------------------------------------------------
// status register bit positions
// ----------------------------------------------------------------
`define ALB_FLAG_C 0
`define ALB_FLAG_Z 1
`define ALB_FLAG_N 2
`define ALB_FLAG_V 3
`define ALB_FLAG_S 4
`define ALB_FLAG_H 5
`define ALB_FLAG_I 7

// ----------------------------------------------------------------
// reset values and fixed operands
// ----------------------------------------------------------------
`define ALB_SREG_RST 8'h00
`define ALB_PC_RST 16'h0000
`define ALB_ALL_ONES 8'hff
`define ALB_ALL_ZERO 8'h00
`define ALB_ZPTR_LO 5'h1e
`define ALB_ZPTR_HI 5'h1f

// ----------------------------------------------------------------
// execution cycles per operation
// ----------------------------------------------------------------
`define ALB_CYC_ONE 3'h1
`define ALB_CYC_WORD 3'h2
`define ALB_CYC_GOTO 3'h2
`define ALB_CYC_ABS_GOTO 3'h3
`define ALB_CYC_SUBR 3'h3
`define ALB_CYC_ABS_SUBR 3'h4
`define ALB_CYC_EXIT 3'h4

// ----------------------------------------------------------------
// register port map
// ----------------------------------------------------------------
`define ALB_ADDR_GPR_LAST 6'h1f
`define ALB_ADDR_SREG 6'h20
`define ALB_ADDR_PC_LO 6'h21
`define ALB_ADDR_PC_HI 6'h22
`define ALB_ADDR_DEPTH 6'h23

`endif

// >>> alb_pkg.sv
// types of the arithmetic, logic and control-transfer execution unit
package alb_pkg;

  typedef enum logic [5:0] {
    ALB_OP_NOP = 6'h00,
    ALB_OP_SUM_TWO_REGS = 6'h01,
    ALB_OP_SUM_WITH_CARRY = 6'h02,
    ALB_OP_WORD_PLUS_IMM = 6'h03,
    ALB_OP_DIFF_REGS = 6'h04,
    ALB_OP_DIFF_IMM = 6'h05,
    ALB_OP_DIFF_BORROW_REGS = 6'h06,
    ALB_OP_DIFF_BORROW_IMM = 6'h07,
    ALB_OP_WORD_MINUS_IMM = 6'h08,
    ALB_OP_BITWISE_CONJ_REGS = 6'h09,
    ALB_OP_BITWISE_CONJ_IMM = 6'h0a,
    ALB_OP_BITWISE_DISJ_REGS = 6'h0b,
    ALB_OP_BITWISE_DISJ_IMM = 6'h0c,
    ALB_OP_BITWISE_XDISJ_REGS = 6'h0d,
    ALB_OP_ONES_INVERT = 6'h0e,
    ALB_OP_TWOS_INVERT = 6'h0f,
    ALB_OP_SET_MASK_BITS = 6'h10,
    ALB_OP_CLEAR_MASK_BITS = 6'h11,
    ALB_OP_PLUS_ONE = 6'h12,
    ALB_OP_MINUS_ONE = 6'h13,
    ALB_OP_ZERO_SIGN_CHECK = 6'h14,
    ALB_OP_ZERO_REGISTER = 6'h15,
    ALB_OP_FILL_ONES = 6'h16,
    ALB_OP_REL_GOTO = 6'h17,
    ALB_OP_PTR_GOTO = 6'h18,
    ALB_OP_ABS_GOTO = 6'h19,
    ALB_OP_REL_SUBR_ENTRY = 6'h1a,
    ALB_OP_PTR_SUBR_ENTRY = 6'h1b,
    ALB_OP_ABS_SUBR_ENTRY = 6'h1c,
    ALB_OP_SUBR_EXIT = 6'h1d,
    ALB_OP_IRQ_EXIT = 6'h1e,
    ALB_OP_EQUAL_SKIP = 6'h1f,
    ALB_OP_COMPARE_REGS = 6'h20,
    ALB_OP_COMPARE_BORROW = 6'h21
  } alb_op_t;

  typedef enum logic [1:0] {
    ALB_ST_IDLE = 2'b00,
    ALB_ST_EXEC = 2'b01,
    ALB_ST_WAIT = 2'b11
  } alb_state_t;

endpackage

// >>> alb_addsub.sv
// adder/subtractor with carry-in and carry, half-carry and overflow out
module alb_addsub #(
  parameter int WIDTH = 8
) (
  // operands
  input wire logic [WIDTH-1:0] i_a,
  input wire logic [WIDTH-1:0] i_b,
  input wire logic i_cin,
  input wire logic i_sub,
  // result
  output logic [WIDTH-1:0] o_res,
  output logic o_carry,
  output logic o_half,
  output logic o_ovf
);
  logic [WIDTH:0] full;
  logic [4:0] nib;

  // top bit of a zero-extended difference is the borrow
  always_comb begin
    if (i_sub) begin
      full = {1'b0, i_a} - {1'b0, i_b} - {{WIDTH{1'b0}}, i_cin};
      nib = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, i_cin};
    end else begin
      full = {1'b0, i_a} + {1'b0, i_b} + {{WIDTH{1'b0}}, i_cin};
      nib = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
    end
  end

  assign o_res = full[WIDTH-1:0];
  assign o_carry = full[WIDTH];
  assign o_half = nib[4];
  assign o_ovf = (i_a[WIDTH-1] ^ full[WIDTH-1]) & ~(i_a[WIDTH-1] ^ i_b[WIDTH-1] ^ i_sub);
endmodule // alb_addsub

// >>> alb_ret_stack.sv
// return-address stack for subroutine entry and exit
module alb_ret_stack #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // push and pop
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic [WIDTH-1:0] i_data,
  output logic [WIDTH-1:0] o_top,
  output logic [7:0] o_depth
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] ptr;
  logic [7:0] count;

  // deepest entries are overwritten when full; count saturates
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ptr <= '0;
      count <= 8'h00;
    end else if (i_push) begin
      mem[ptr] <= i_data;
      ptr <= ptr + 1'b1;
      if (count != 8'(DEPTH)) count <= count + 8'h01;
    end else if (i_pop) begin
      ptr <= ptr - 1'b1;
      if (count != 8'h00) count <= count - 8'h01;
    end
  end

  assign o_top = mem[ptr - 1'b1];
  assign o_depth = count;
endmodule // alb_ret_stack

// >>> alb_exec.sv
// execution unit for arithmetic, logic and control-transfer operations
`include "alb_cfg.svh"

// Notes on behaviour
// - add two registers, optional carry, one cycle
// - word plus immediate on pair, two cycles
// - subtract register/constant; compares keep destination
// - subtract with borrow, register or constant
// - word minus immediate on pair, two cycles
// - conjunction updates only zero, negative, overflow
// - inclusive/exclusive or, one cycle
// - ones and twos inversion, one cycle
// - set or clear mask bits
// - increment/decrement leave carry alone
// - check, zero, fill ones registers
// - relative, pointer, absolute goto timings
// - subroutine entry/exit; irq exit sets enable
// - equal skip over next instruction
module alb_exec
  import alb_pkg::*;
#(
  parameter int STACK_DEPTH = 16
) (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // operation issue
  input wire logic I_OP_VALID,
  input wire logic [5:0] I_OP_CODE,
  input wire logic [4:0] I_OP_DST,
  input wire logic [4:0] I_OP_SRC,
  input wire logic [7:0] I_OP_IMM,
  input wire logic [15:0] I_OP_TARGET,
  input wire logic I_NEXT_TWO_WORD,
  output logic O_OP_READY,
  output logic O_OP_DONE,
  // program state
  output logic [15:0] O_PC,
  output logic [7:0] O_SREG,
  // register port
  input wire logic [5:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [7:0] O_REG_RDATA
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] op_cycles(input alb_op_t op);
    case (op)
      ALB_OP_WORD_PLUS_IMM, ALB_OP_WORD_MINUS_IMM: op_cycles = `ALB_CYC_WORD;
      ALB_OP_REL_GOTO, ALB_OP_PTR_GOTO: op_cycles = `ALB_CYC_GOTO;
      ALB_OP_ABS_GOTO: op_cycles = `ALB_CYC_ABS_GOTO;
      ALB_OP_REL_SUBR_ENTRY, ALB_OP_PTR_SUBR_ENTRY: op_cycles = `ALB_CYC_SUBR;
      ALB_OP_ABS_SUBR_ENTRY: op_cycles = `ALB_CYC_ABS_SUBR;
      ALB_OP_SUBR_EXIT, ALB_OP_IRQ_EXIT: op_cycles = `ALB_CYC_EXIT;
      default: op_cycles = `ALB_CYC_ONE;
    endcase
  endfunction

  // absolute forms carry their target in a second program word
  function automatic logic two_word(input alb_op_t op);
    two_word = (op == ALB_OP_ABS_GOTO) || (op == ALB_OP_ABS_SUBR_ENTRY);
  endfunction

  // equal_skip length depends on data, so it is never ready in the cycle right after issue
  function automatic logic single_cycle(input alb_op_t op);
    single_cycle = (op_cycles(op) == `ALB_CYC_ONE) && (op != ALB_OP_EQUAL_SKIP);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  alb_state_t state, next_state;
  logic [2:0] cnt, next_cnt;
  logic ready, next_ready;
  logic done;
  alb_op_t op;
  logic [4:0] op_dst, op_src;
  logic [7:0] op_imm;
  logic [15:0] op_target;
  logic op_next_two;
  logic [7:0] gpr [32];
  logic [15:0] pc, next_pc;
  logic [7:0] sreg, next_sreg;
  logic [7:0] rdata;
  logic take, exec;
  logic [2:0] extra;

  assign take = ready & I_OP_VALID;
  assign exec = (state == ALB_ST_EXEC);

  // ----------------------------------------------------------------
  // operand fetch and arithmetic
  // ----------------------------------------------------------------
  logic [7:0] rd, rr;
  logic [4:0] pair_lo, pair_hi;
  logic [7:0] a8, b8, r8;
  logic cin8, sub8, c8, h8, v8;
  logic [15:0] r16;
  logic c16, v16;

  assign rd = gpr[op_dst];
  assign rr = gpr[op_src];
  assign pair_lo = {op_dst[4:1], 1'b0};
  assign pair_hi = {op_dst[4:1], 1'b1};

  always_comb begin
    a8 = rd;
    b8 = rr;
    cin8 = 1'b0;
    sub8 = 1'b0;
    case (op)
      ALB_OP_SUM_WITH_CARRY: cin8 = sreg[`ALB_FLAG_C];
      ALB_OP_DIFF_REGS, ALB_OP_COMPARE_REGS: sub8 = 1'b1;
      ALB_OP_DIFF_IMM: begin
        b8 = op_imm;
        sub8 = 1'b1;
      end
      ALB_OP_DIFF_BORROW_REGS, ALB_OP_COMPARE_BORROW: begin
        sub8 = 1'b1;
        cin8 = sreg[`ALB_FLAG_C];
      end
      ALB_OP_DIFF_BORROW_IMM: begin
        b8 = op_imm;
        sub8 = 1'b1;
        cin8 = sreg[`ALB_FLAG_C];
      end
      ALB_OP_TWOS_INVERT: begin
        a8 = `ALB_ALL_ZERO;
        b8 = rd;
        sub8 = 1'b1;
      end
      ALB_OP_PLUS_ONE: b8 = 8'h01;
      ALB_OP_MINUS_ONE: begin
        b8 = 8'h01;
        sub8 = 1'b1;
      end
      default: ;
    endcase
  end

  alb_addsub #(.WIDTH(8)) u_add8 (
    .i_a(a8),
    .i_b(b8),
    .i_cin(cin8),
    .i_sub(sub8),
    .o_res(r8),
    .o_carry(c8),
    .o_half(h8),
    .o_ovf(v8)
  );

  // word forms wrap modulo 65536, immediate zero-extended
  alb_addsub #(.WIDTH(16)) u_add16 (
    .i_a({gpr[pair_hi], gpr[pair_lo]}),
    .i_b({8'h00, op_imm}),
    .i_cin(1'b0),
    .i_sub(op == ALB_OP_WORD_MINUS_IMM),
    .o_res(r16),
    .o_carry(c16),
    .o_half(),
    .o_ovf(v16)
  );

  // ----------------------------------------------------------------
  // result and flag selection
  // ----------------------------------------------------------------
  logic [7:0] res, fmask, fval;
  logic wr8, wr16;
  logic res_v;

  always_comb begin
    res = r8;
    res_v = 1'b0;
    wr8 = 1'b0;
    wr16 = 1'b0;
    fmask = 8'h00;
    case (op)
      ALB_OP_SUM_TWO_REGS, ALB_OP_SUM_WITH_CARRY, ALB_OP_DIFF_REGS, ALB_OP_DIFF_IMM,
      ALB_OP_DIFF_BORROW_REGS, ALB_OP_DIFF_BORROW_IMM, ALB_OP_TWOS_INVERT: begin
        wr8 = 1'b1;
        res_v = v8;
        fmask = 8'h2f;
      end
      ALB_OP_COMPARE_REGS, ALB_OP_COMPARE_BORROW: begin
        res_v = v8;
        fmask = 8'h2f;
      end
      ALB_OP_WORD_PLUS_IMM, ALB_OP_WORD_MINUS_IMM: begin
        wr16 = 1'b1;
        fmask = 8'h1f;
      end
      ALB_OP_BITWISE_CONJ_REGS, ALB_OP_BITWISE_CONJ_IMM, ALB_OP_ZERO_SIGN_CHECK: begin
        res = rd & ((op == ALB_OP_BITWISE_CONJ_IMM) ? op_imm : rr);
        if (op == ALB_OP_ZERO_SIGN_CHECK) res = rd;
        wr8 = (op != ALB_OP_ZERO_SIGN_CHECK);
        fmask = 8'h0e;
      end
      ALB_OP_BITWISE_DISJ_REGS, ALB_OP_BITWISE_DISJ_IMM, ALB_OP_SET_MASK_BITS: begin
        res = rd | ((op == ALB_OP_BITWISE_DISJ_REGS) ? rr : op_imm);
        wr8 = 1'b1;
        fmask = 8'h0e;
      end
      ALB_OP_BITWISE_XDISJ_REGS: begin
        res = rd ^ rr;
        wr8 = 1'b1;
        fmask = 8'h0e;
      end
      ALB_OP_ZERO_REGISTER: begin
        res = rd ^ rd;
        wr8 = 1'b1;
        fmask = 8'h0e;
      end
      ALB_OP_CLEAR_MASK_BITS: begin
        res = rd & (`ALB_ALL_ONES - op_imm);
        wr8 = 1'b1;
        fmask = 8'h0e;
      end
      ALB_OP_ONES_INVERT: begin
        res = `ALB_ALL_ONES - rd;
        wr8 = 1'b1;
        fmask = 8'h0f;
      end
      ALB_OP_PLUS_ONE, ALB_OP_MINUS_ONE: begin
        wr8 = 1'b1;
        res_v = v8;
        fmask = 8'h0e;
      end
      ALB_OP_FILL_ONES: begin
        res = `ALB_ALL_ONES;
        wr8 = 1'b1;
      end
      ALB_OP_IRQ_EXIT: fmask = 8'h80;
      default: ;
    endcase
  end

  always_comb begin
    fval = 8'h00;
    if (wr16) begin
      fval[`ALB_FLAG_Z] = (r16 == 16'h0000);
      fval[`ALB_FLAG_N] = r16[15];
      fval[`ALB_FLAG_V] = v16;
      fval[`ALB_FLAG_C] = c16;
      fval[`ALB_FLAG_S] = r16[15] ^ v16;
    end else begin
      fval[`ALB_FLAG_Z] = (res == 8'h00);
      fval[`ALB_FLAG_N] = res[7];
      fval[`ALB_FLAG_V] = res_v;
      // ones inversion always reports carry set
      fval[`ALB_FLAG_C] = (op == ALB_OP_ONES_INVERT) ? 1'b1 : c8;
      fval[`ALB_FLAG_H] = h8;
    end
    fval[`ALB_FLAG_I] = 1'b1;
  end

  // ----------------------------------------------------------------
  // program counter, stack and cycle count
  // ----------------------------------------------------------------
  logic equal, push, pop;
  logic [15:0] stack_top, ret_addr;
  logic [7:0] depth;

  assign equal = (rd == rr);
  assign push = exec && (op == ALB_OP_REL_SUBR_ENTRY || op == ALB_OP_PTR_SUBR_ENTRY ||
                         op == ALB_OP_ABS_SUBR_ENTRY);
  assign pop = exec && (op == ALB_OP_SUBR_EXIT || op == ALB_OP_IRQ_EXIT);
  assign ret_addr = pc + (two_word(op) ? 16'h0002 : 16'h0001);

  alb_ret_stack #(.DEPTH(STACK_DEPTH), .WIDTH(16)) u_stack (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_push(push),
    .i_pop(pop),
    .i_data(ret_addr),
    .o_top(stack_top),
    .o_depth(depth)
  );

  always_comb begin
    next_pc = ret_addr;
    extra = op_cycles(op) - 3'h1;
    case (op)
      ALB_OP_REL_GOTO, ALB_OP_REL_SUBR_ENTRY: next_pc = pc + op_target + 16'h0001;
      ALB_OP_PTR_GOTO, ALB_OP_PTR_SUBR_ENTRY:
        next_pc = {gpr[`ALB_ZPTR_HI], gpr[`ALB_ZPTR_LO]};
      ALB_OP_ABS_GOTO, ALB_OP_ABS_SUBR_ENTRY: next_pc = op_target;
      ALB_OP_SUBR_EXIT, ALB_OP_IRQ_EXIT: next_pc = stack_top;
      ALB_OP_EQUAL_SKIP: begin
        if (equal) begin
          next_pc = pc + (op_next_two ? 16'h0003 : 16'h0002);
          extra = op_next_two ? 3'h2 : 3'h1;
        end
      end
      default: ;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_ready = ready;
    if (take) begin
      next_state = ALB_ST_EXEC;
      next_cnt = 3'h0;
      next_ready = single_cycle(alb_op_t'(I_OP_CODE));
    end else begin
      case (state)
        ALB_ST_IDLE: next_ready = 1'b1;
        ALB_ST_EXEC: begin
          if (extra == 3'h0) begin
            next_state = ALB_ST_IDLE;
            next_ready = 1'b1;
          end else begin
            next_state = ALB_ST_WAIT;
            next_cnt = extra;
            next_ready = (extra == 3'h1);
          end
        end
        ALB_ST_WAIT: begin
          next_cnt = cnt - 3'h1;
          if (cnt == 3'h1) begin
            next_state = ALB_ST_IDLE;
            next_ready = 1'b1;
          end else begin
            next_ready = (cnt == 3'h2);
          end
        end
        default: begin
          next_state = ALB_ST_IDLE;
          next_ready = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      state <= ALB_ST_IDLE;
      cnt <= 3'h0;
      ready <= 1'b1;
      done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ready <= next_ready;
      done <= (exec && extra == 3'h0) || (state == ALB_ST_WAIT && cnt == 3'h1);
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      op <= ALB_OP_NOP;
      op_dst <= 5'h00;
      op_src <= 5'h00;
      op_imm <= 8'h00;
      op_target <= 16'h0000;
      op_next_two <= 1'b0;
    end else if (take) begin
      op <= alb_op_t'(I_OP_CODE);
      op_dst <= I_OP_DST;
      op_src <= I_OP_SRC;
      op_imm <= I_OP_IMM;
      op_target <= I_OP_TARGET;
      op_next_two <= I_NEXT_TWO_WORD;
    end
  end

  // ----------------------------------------------------------------
  // architectural state: execution wins over the register port
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      for (int i = 0; i < 32; i++) gpr[i] <= 8'h00;
    end else if (exec && wr8) begin
      gpr[op_dst] <= res;
    end else if (exec && wr16) begin
      gpr[pair_lo] <= r16[7:0];
      gpr[pair_hi] <= r16[15:8];
    end else if (I_REG_WR && I_REG_ADDR <= `ALB_ADDR_GPR_LAST) begin
      gpr[I_REG_ADDR[4:0]] <= I_REG_WDATA;
    end
  end

  assign next_sreg = (sreg & ~fmask) | (fval & fmask);

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      sreg <= `ALB_SREG_RST;
    end else if (exec) begin
      sreg <= next_sreg;
    end else if (I_REG_WR && I_REG_ADDR == `ALB_ADDR_SREG) begin
      sreg <= I_REG_WDATA;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      pc <= `ALB_PC_RST;
    end else if (exec) begin
      pc <= next_pc;
    end else if (I_REG_WR && I_REG_ADDR == `ALB_ADDR_PC_LO) begin
      pc[7:0] <= I_REG_WDATA;
    end else if (I_REG_WR && I_REG_ADDR == `ALB_ADDR_PC_HI) begin
      pc[15:8] <= I_REG_WDATA;
    end
  end

  // read data stands for one cycle only, zero otherwise and when unmapped
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST || !I_REG_RD) begin
      rdata <= 8'h00;
    end else if (I_REG_ADDR <= `ALB_ADDR_GPR_LAST) begin
      rdata <= gpr[I_REG_ADDR[4:0]];
    end else begin
      case (I_REG_ADDR)
        `ALB_ADDR_SREG: rdata <= sreg;
        `ALB_ADDR_PC_LO: rdata <= pc[7:0];
        `ALB_ADDR_PC_HI: rdata <= pc[15:8];
        `ALB_ADDR_DEPTH: rdata <= depth;
        default: rdata <= 8'h00;
      endcase
    end
  end

  assign O_OP_READY = ready;
  assign O_OP_DONE = done;
  assign O_PC = pc;
  assign O_SREG = sreg;
  assign O_REG_RDATA = rdata;

endmodule // alb_exec

// >>> alb_exec_chk.sv
// timing and flag assertions for the execution unit
module alb_exec_chk
  import alb_pkg::*;
#(
  parameter int STACK_DEPTH = 16
) (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // issue and state
  input wire logic I_OP_VALID,
  input wire logic [5:0] I_OP_CODE,
  input wire logic [15:0] I_OP_TARGET,
  input wire logic O_OP_READY,
  input wire logic O_OP_DONE,
  input wire logic [15:0] O_PC,
  input wire logic [7:0] O_SREG
);
  // ----
  // issue decode
  // ----
  alb_op_t oc;
  logic tk;
  logic wrd;
  logic one;
  logic two;
  assign oc = alb_op_t'(I_OP_CODE);
  assign tk = I_OP_VALID && O_OP_READY;
  assign wrd = oc inside {ALB_OP_WORD_PLUS_IMM, ALB_OP_WORD_MINUS_IMM};
  assign one = !wrd && oc inside {[ALB_OP_SUM_TWO_REGS:ALB_OP_FILL_ONES],
    ALB_OP_COMPARE_REGS, ALB_OP_COMPARE_BORROW};
  assign two = wrd || oc inside {ALB_OP_REL_GOTO, ALB_OP_PTR_GOTO};

  default clocking @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);

  // ----
  // assertions
  // ----
  one_cycle_a: assert property (tk && one |=> O_OP_READY ##1 O_OP_DONE)
    else $error("single cycle op timing wrong");
  two_cycle_a: assert property (tk && two |-> ##2 !O_OP_DONE ##1 O_OP_DONE)
    else $error("two cycle op timing wrong");
  word_sign_a: assert property (tk && wrd
    |-> ##2 O_SREG[4] == (O_SREG[2] ^ O_SREG[3])) else $error("sign flag wrong");
  rel_target_a: assert property (tk && oc == ALB_OP_REL_GOTO
    |=> ##1 O_PC == $past(O_PC) + $past(I_OP_TARGET, 2) + 16'h0001)
    else $error("relative goto target wrong");
  abs_goto_a: assert property (tk && oc == ALB_OP_ABS_GOTO
    |-> ##2 (O_PC == $past(I_OP_TARGET, 2) && !O_OP_DONE) ##1 !O_OP_DONE ##1 O_OP_DONE)
    else $error("absolute goto wrong");
  subr_time_a: assert property (tk && oc inside {ALB_OP_REL_SUBR_ENTRY,
    ALB_OP_PTR_SUBR_ENTRY} |-> ##2 !O_OP_DONE [*2] ##1 O_OP_DONE)
    else $error("subroutine entry timing wrong");
  exit_time_a: assert property (tk && oc inside {ALB_OP_ABS_SUBR_ENTRY,
    ALB_OP_SUBR_EXIT, ALB_OP_IRQ_EXIT} |-> ##2 !O_OP_DONE [*3] ##1 O_OP_DONE)
    else $error("four cycle op timing wrong");
  irq_flag_a: assert property (tk && oc == ALB_OP_IRQ_EXIT |-> ##2 O_SREG[7])
    else $error("interrupt enable not set");
  skip_wait_a: assert property (tk && oc == ALB_OP_EQUAL_SKIP
    |=> !O_OP_READY ##[1:3] O_OP_DONE) else $error("equal skip timing wrong");
  carry_keep_a: assert property (tk && oc inside {ALB_OP_PLUS_ONE, ALB_OP_MINUS_ONE}
    |-> ##2 $stable(O_SREG[0])) else $error("carry changed by step op");
  fill_flags_a: assert property (tk && oc == ALB_OP_FILL_ONES
    |-> ##2 $stable(O_SREG)) else $error("fill changed flags");
endmodule // alb_exec_chk

bind alb_exec alb_exec_chk #(.STACK_DEPTH(STACK_DEPTH)) u_chk (.I_REF_CLK, .I_RST,
  .I_OP_VALID, .I_OP_CODE, .I_OP_TARGET, .O_OP_READY, .O_OP_DONE, .O_PC, .O_SREG);

// >>> alb_exec_test.sv
// self-checking bench for the execution unit
module alb_exec_test import alb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, vld = 0, two = 0, wr = 0, rd = 0;
  logic [5:0] code = 0, addr = 0;
  logic [4:0] dst = 0, src = 0;
  logic [7:0] imm = 0, wdat = 0;
  logic [15:0] tgt = 0;
  logic rdy, done;
  logic [15:0] pc_o, pc;
  logic [7:0] sreg_o, rdat, sr;
  logic [7:0] rf [32];
  logic [15:0] stk [$];
  int err_count = 0, checked = 0, cyc = 0, ndone = 0, nops = 0, seed = 15906;

  alb_exec dut (.I_REF_CLK(clk), .I_RST(rst), .I_OP_VALID(vld), .I_OP_CODE(code),
    .I_OP_DST(dst), .I_OP_SRC(src), .I_OP_IMM(imm), .I_OP_TARGET(tgt),
    .I_NEXT_TWO_WORD(two), .O_OP_READY(rdy), .O_OP_DONE(done), .O_PC(pc_o),
    .O_SREG(sreg_o), .I_REG_ADDR(addr), .I_REG_WDATA(wdat), .I_REG_WR(wr),
    .I_REG_RD(rd), .O_REG_RDATA(rdat));

  initial begin
    forever #25 clk = ~clk;
  end

  // ----
  // checking and closing
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(negedge clk) begin
    cyc++;
    if (done === 1'b1) ndone++;
    if (cyc == 20000) begin
      err_count++;
      final_report;
    end
  end

  // ----
  // register port
  // ----
  task automatic wrr(logic [5:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a < 6'h20) rf[a[4:0]] = d;
    if (a == 6'h20) sr = d;
    if (a == 6'h21) pc[7:0] = d;
    if (a == 6'h22) pc[15:8] = d;
  endtask

  task automatic rdc(logic [5:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(16'(rdat), 16'(e));
  endtask

  // ----
  // reference model
  // ----
  function automatic logic [10:0] as8(logic [7:0] a, logic [7:0] b, logic ci, logic sb);
    logic [8:0] t;
    logic h;
    t = sb ? {1'b0, a} - {1'b0, b} - 9'(ci) : {1'b0, a} + {1'b0, b} + 9'(ci);
    h = sb ? {1'b0, a[3:0]} < {1'b0, b[3:0]} + 5'(ci)
      : {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci) > 5'h0f;
    return {t[8], h, ((a[7] ^ b[7]) == sb) && (t[7] != a[7]), t[7:0]};
  endfunction

  task automatic ar(logic [10:0] q, logic [4:0] d, logic w);
    if (w) rf[d] = q[7:0];
    sr[0] = q[10];
    sr[5] = q[9];
    sr[3] = q[8];
    sr[2] = q[7];
    sr[1] = q[7:0] == 8'h00;
  endtask

  task automatic lg(logic [7:0] r, logic [4:0] d);
    rf[d] = r;
    sr[3] = 1'b0;
    sr[2] = r[7];
    sr[1] = r == 8'h00;
  endtask

  task automatic mdl(alb_op_t op, logic [4:0] d, logic [4:0] s, logic [7:0] k,
      logic [15:0] t, logic tw);
    logic [7:0] a;
    logic [7:0] b;
    logic [1:0] ch;
    logic o;
    logic [15:0] z;
    logic [15:0] np;
    logic [16:0] w;
    a = rf[d];
    b = rf[s];
    ch = {sr[5], sr[0]};
    z = {rf[31], rf[30]};
    w = {1'b0, rf[{d[4:1], 1'b1}], rf[{d[4:1], 1'b0}]};
    o = w[15];
    np = pc + 16'h0001;
    case (op)
      ALB_OP_SUM_TWO_REGS, ALB_OP_SUM_WITH_CARRY: ar(as8(a, b,
        op == ALB_OP_SUM_WITH_CARRY && sr[0], 1'b0), d, 1'b1);
      ALB_OP_DIFF_REGS, ALB_OP_COMPARE_REGS: ar(as8(a, b, 1'b0, 1'b1),
        d, op == ALB_OP_DIFF_REGS);
      ALB_OP_DIFF_BORROW_REGS, ALB_OP_COMPARE_BORROW: ar(as8(a, b, sr[0], 1'b1),
        d, op == ALB_OP_DIFF_BORROW_REGS);
      ALB_OP_DIFF_IMM: ar(as8(a, k, 1'b0, 1'b1), d, 1'b1);
      ALB_OP_DIFF_BORROW_IMM: ar(as8(a, k, sr[0], 1'b1), d, 1'b1);
      ALB_OP_TWOS_INVERT: ar(as8(8'h00, a, 1'b0, 1'b1), d, 1'b1);
      ALB_OP_BITWISE_CONJ_REGS: lg(a & b, d);
      ALB_OP_BITWISE_CONJ_IMM: lg(a & k, d);
      ALB_OP_CLEAR_MASK_BITS: lg(a & ~k, d);
      ALB_OP_BITWISE_DISJ_REGS: lg(a | b, d);
      ALB_OP_BITWISE_DISJ_IMM, ALB_OP_SET_MASK_BITS: lg(a | k, d);
      ALB_OP_BITWISE_XDISJ_REGS: lg(a ^ b, d);
      ALB_OP_ZERO_SIGN_CHECK: lg(a, d);
      ALB_OP_ZERO_REGISTER: lg(8'h00, d);
      ALB_OP_FILL_ONES: rf[d] = 8'hff;
      ALB_OP_ONES_INVERT: begin
        lg(~a, d);
        sr[0] = 1'b1;
      end
      ALB_OP_PLUS_ONE, ALB_OP_MINUS_ONE: begin
        ar(as8(a, 8'h01, 1'b0, op == ALB_OP_MINUS_ONE), d, 1'b1);
        {sr[5], sr[0]} = ch;
      end
      ALB_OP_WORD_PLUS_IMM, ALB_OP_WORD_MINUS_IMM: begin
        w = op == ALB_OP_WORD_PLUS_IMM ? w + 17'(k) : w - 17'(k);
        {rf[{d[4:1], 1'b1}], rf[{d[4:1], 1'b0}]} = w[15:0];
        sr[0] = w[16];
        sr[1] = w[15:0] == 16'h0000;
        sr[2] = w[15];
        sr[3] = (o ^ w[15]) && (o == (op == ALB_OP_WORD_MINUS_IMM));
        sr[4] = sr[2] ^ sr[3];
      end
      ALB_OP_REL_GOTO: np = pc + t + 16'h0001;
      ALB_OP_PTR_GOTO: np = z;
      ALB_OP_ABS_GOTO: np = t;
      ALB_OP_REL_SUBR_ENTRY, ALB_OP_PTR_SUBR_ENTRY: begin
        stk.push_back(np);
        np = op == ALB_OP_PTR_SUBR_ENTRY ? z : pc + t + 16'h0001;
      end
      ALB_OP_ABS_SUBR_ENTRY: begin
        stk.push_back(pc + 16'h0002);
        np = t;
      end
      ALB_OP_SUBR_EXIT, ALB_OP_IRQ_EXIT: begin
        np = stk.pop_back();
        if (op == ALB_OP_IRQ_EXIT) sr[7] = 1'b1;
      end
      ALB_OP_EQUAL_SKIP: if (a == b) np = pc + (tw ? 16'h0003 : 16'h0002);
      default: ;
    endcase
    pc = np;
  endtask

  // ----
  // issue and scan
  // ----
  // valid stays up between ops so single-cycle ops go back to back
  task automatic put(alb_op_t op, logic [4:0] d, logic [4:0] s, logic [7:0] k,
      logic [15:0] t, logic tw);
    int n = 0;
    logic ok;
    vld <= 1'b1;
    code <= op;
    dst <= d;
    src <= s;
    imm <= k;
    tgt <= t;
    two <= tw;
    do begin
      @(negedge clk);
      ok = rdy === 1'b1;
      @(posedge clk);
      n++;
    end while (!ok && n < 10);
    mdl(op, d, s, k, t, tw);
    nops++;
  endtask

  task automatic scan;
    vld <= 1'b0;
    repeat (6) @(posedge clk);
    #1 chk(pc_o, pc);
    chk(16'(sreg_o), 16'(sr));
    for (int i = 0; i < 32; i++) begin
      rdc(6'(i), rf[i]);
    end
    rdc(6'h20, sr);
    rdc(6'h21, pc[7:0]);
    rdc(6'h22, pc[15:8]);
    rdc(6'h23, 8'(stk.size()));
    rdc(6'h3f, 8'h00);
    chk(16'(ndone), 16'(nops));
  endtask

  initial begin
    alb_op_t op;
    logic [31:0] r;
    sr = 8'h00;
    pc = 16'h0000;
    foreach (rf[i]) rf[i] = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 35; i++) begin
      wrr(6'(i), 8'($random(seed)));
    end
    wrr(6'h05, 8'h80);
    wrr(6'h06, 8'h7f);
    wrr(6'h18, 8'h00);
    wrr(6'h19, 8'h00);
    wrr(6'h3f, 8'h55);
    put(ALB_OP_TWOS_INVERT, 5'h05, 5'h00, 8'h00, 16'h0000, 1'b0);
    put(ALB_OP_PLUS_ONE, 5'h06, 5'h00, 8'h00, 16'h0000, 1'b0);
    put(ALB_OP_WORD_MINUS_IMM, 5'h18, 5'h00, 8'h01, 16'h0000, 1'b0);
    put(ALB_OP_WORD_PLUS_IMM, 5'h19, 5'h00, 8'h01, 16'h0000, 1'b0);
    put(ALB_OP_EQUAL_SKIP, 5'h03, 5'h03, 8'h00, 16'h0000, 1'b1);
    put(ALB_OP_EQUAL_SKIP, 5'h03, 5'h03, 8'h00, 16'h0000, 1'b0);
    put(ALB_OP_ABS_SUBR_ENTRY, 5'h00, 5'h00, 8'h00, 16'hfffe, 1'b0);
    put(ALB_OP_IRQ_EXIT, 5'h00, 5'h00, 8'h00, 16'h0000, 1'b0);
    scan;
    for (int g = 0; g < 24; g++) begin
      for (int i = 0; i < 16; i++) begin
        op = alb_op_t'(6'h01 + 6'($unsigned($random(seed)) % 33));
        if (op inside {ALB_OP_SUBR_EXIT, ALB_OP_IRQ_EXIT} && stk.size() == 0)
          op = ALB_OP_REL_SUBR_ENTRY;
        if (op inside {[ALB_OP_REL_SUBR_ENTRY:ALB_OP_ABS_SUBR_ENTRY]} && stk.size() > 12)
          op = ALB_OP_SUBR_EXIT;
        r = $random(seed);
        put(op, r[4:0], r[9:5], r[17:10], r[31:16], r[18]);
      end
      scan;
    end
    final_report;
  end
endmodule // alb_exec_test
